/* File: shared/bcbx_params.svh */
`ifndef BCBX_PARAMS_SVH
`define BCBX_PARAMS_SVH

`define BCBX_PC_W 15
`define BCBX_LIT_W 11
`define BCBX_REL_W 9
`define BCBX_ACC_W 8
`define BCBX_ADDR_W 7
`define BCBX_BIT_W 3
`define BCBX_LATCH_W 7
`define BCBX_CALL_LATCH_MSB 6
`define BCBX_CALL_LATCH_LSB 3
`define BCBX_PC_RESET 15'h0000
`define BCBX_PC_STEP 15'h0001

`endif

/* File: shared/bcbx_pkg.sv */
`include "bcbx_params.svh"

package bcbx_pkg;

  typedef enum logic [2:0]
  {
    OP_OTHER = 3'b000,
    OP_RELATIVE_JUMP = 3'b001,
    OP_JUMP_BY_ACCUMULATOR = 3'b010,
    OP_SET_BIT_OP = 3'b011,
    OP_SKIP_IF_BIT_LOW = 3'b100,
    OP_SKIP_IF_BIT_HIGH = 3'b101,
    OP_SUBROUTINE_CALL = 3'b110,
    OP_INDIRECT_SUBROUTINE_CALL = 3'b111
  } bcbx_op_t;

  typedef enum logic [1:0]
  {
    ST_EXEC = 2'b00,
    ST_BUBBLE = 2'b01,
    ST_SKIP = 2'b10
  } bcbx_state_t;

  typedef struct packed
  {
    bcbx_state_t state;
    logic [`BCBX_PC_W-1:0] pc;
    logic flush;
    logic push;
    logic [`BCBX_PC_W-1:0] push_addr;
    logic wr_en;
    logic [`BCBX_ADDR_W-1:0] wr_addr;
    logic [`BCBX_ACC_W-1:0] wr_data;
  } bcbx_regs_t;

endpackage

/* File: src/bcbx_decode.sv */
`timescale 1ns/1ps
`include "bcbx_params.svh"

module bcbx_decode
(
  // Instruction
  input wire bcbx_pkg::bcbx_op_t i_op,
  input wire logic [`BCBX_LIT_W-1:0] i_lit,
  input wire logic [`BCBX_BIT_W-1:0] i_bit_sel,
  input wire logic [`BCBX_ACC_W-1:0] i_file_data,
  // Core state
  input wire logic [`BCBX_PC_W-1:0] i_pc,
  input wire logic [`BCBX_ACC_W-1:0] i_acc,
  input wire logic [`BCBX_LATCH_W-1:0] i_latch,
  // Decisions
  output logic o_jump,
  output logic o_push,
  output logic o_skip,
  output logic o_set,
  output logic [`BCBX_PC_W-1:0] o_target,
  output logic [`BCBX_ACC_W-1:0] o_set_data
);
  import bcbx_pkg::*;

  function automatic logic test_bit(input logic [`BCBX_ACC_W-1:0] data, input logic [`BCBX_BIT_W-1:0] sel);
    test_bit = data[sel];
  endfunction

  logic [`BCBX_PC_W-1:0] pc_inc;
  logic tested;

  assign pc_inc = i_pc + `BCBX_PC_STEP;
  assign tested = test_bit(i_file_data, i_bit_sel);

  always_comb
  begin
    o_jump = 1'b0;
    o_push = 1'b0;
    o_skip = 1'b0;
    o_set = 1'b0;
    o_target = pc_inc;
    o_set_data = i_file_data | (8'h01 << i_bit_sel);
    case (i_op)
      OP_RELATIVE_JUMP:
      begin
        o_jump = 1'b1;
        // The offset is signed, so the upper bits extend its sign.
        o_target = pc_inc + {{(`BCBX_PC_W-`BCBX_REL_W){i_lit[`BCBX_REL_W-1]}}, i_lit[`BCBX_REL_W-1:0]};
      end
      OP_JUMP_BY_ACCUMULATOR:
      begin
        o_jump = 1'b1;
        o_target = pc_inc + {{(`BCBX_PC_W-`BCBX_ACC_W){1'b0}}, i_acc};
      end
      OP_SET_BIT_OP:
      begin
        o_set = 1'b1;
      end
      OP_SKIP_IF_BIT_LOW:
      begin
        o_skip = !tested;
      end
      OP_SKIP_IF_BIT_HIGH:
      begin
        o_skip = tested;
      end
      OP_SUBROUTINE_CALL:
      begin
        o_jump = 1'b1;
        o_push = 1'b1;
        o_target = {i_latch[`BCBX_CALL_LATCH_MSB:`BCBX_CALL_LATCH_LSB], i_lit};
      end
      OP_INDIRECT_SUBROUTINE_CALL:
      begin
        o_jump = 1'b1;
        o_push = 1'b1;
        o_target = {i_latch, i_acc};
      end
      default:
      begin
        o_jump = 1'b0;
      end
    endcase
  end
endmodule

/* File: src/bcbx_core.sv */
`timescale 1ns/1ps
`include "bcbx_params.svh"

module bcbx_core
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Instruction from the fetch unit, for the address on o_fetch_addr
  input wire logic i_valid,
  input wire bcbx_pkg::bcbx_op_t i_op,
  input wire logic [`BCBX_LIT_W-1:0] i_lit,
  input wire logic [`BCBX_ADDR_W-1:0] i_file_addr,
  input wire logic [`BCBX_BIT_W-1:0] i_bit_sel,
  input wire logic [`BCBX_ACC_W-1:0] i_file_data,
  // Core operands
  input wire logic [`BCBX_ACC_W-1:0] i_acc,
  input wire logic [`BCBX_LATCH_W-1:0] i_latch,
  // Fetch control
  output logic [`BCBX_PC_W-1:0] o_fetch_addr,
  output logic o_ready,
  output logic o_flush,
  // Return stack
  output logic o_push,
  output logic [`BCBX_PC_W-1:0] o_push_addr,
  // Data register write
  output logic o_wr_en,
  output logic [`BCBX_ADDR_W-1:0] o_wr_addr,
  output logic [`BCBX_ACC_W-1:0] o_wr_data
);
  import bcbx_pkg::*;

  // The counter wraps in its own width, so the carry out of the top bit is dropped.
  function automatic logic [`BCBX_PC_W-1:0] pc_plus_one(input logic [`BCBX_PC_W-1:0] pc);
    pc_plus_one = pc + `BCBX_PC_STEP;
  endfunction

  bcbx_regs_t r_reg;
  bcbx_regs_t r_next;
  logic dec_jump;
  logic dec_push;
  logic dec_skip;
  logic dec_set;
  logic [`BCBX_PC_W-1:0] dec_target;
  logic [`BCBX_ACC_W-1:0] dec_set_data;
  logic exec;

  bcbx_decode u_decode
  (
    .i_op(i_op),
    .i_lit(i_lit),
    .i_bit_sel(i_bit_sel),
    .i_file_data(i_file_data),
    .i_pc(r_reg.pc),
    .i_acc(i_acc),
    .i_latch(i_latch),
    .o_jump(dec_jump),
    .o_push(dec_push),
    .o_skip(dec_skip),
    .o_set(dec_set),
    .o_target(dec_target),
    .o_set_data(dec_set_data)
  );

  // An instruction is only executed in the normal state; the bubble ignores the inputs.
  assign exec = i_valid && (r_reg.state == ST_EXEC);

  always_comb
  begin
    r_next = r_reg;
    r_next.flush = 1'b0;
    r_next.push = 1'b0;
    r_next.wr_en = 1'b0;
    case (r_reg.state)
      ST_EXEC:
      begin
        if (i_valid)
        begin
          if (dec_jump)
          begin
            // The fetched successor is dropped, which costs the second cycle.
            r_next.pc = dec_target;
            r_next.state = ST_BUBBLE;
            r_next.flush = 1'b1;
            r_next.push = dec_push;
            r_next.push_addr = pc_plus_one(r_reg.pc);
          end
          else
          begin
            r_next.pc = pc_plus_one(r_reg.pc);
            if (dec_skip)
            begin
              r_next.state = ST_SKIP;
            end
            if (dec_set)
            begin
              r_next.wr_en = 1'b1;
              r_next.wr_addr = i_file_addr;
              r_next.wr_data = dec_set_data;
            end
          end
        end
      end
      ST_BUBBLE:
      begin
        r_next.state = ST_EXEC;
      end
      ST_SKIP:
      begin
        // The skipped instruction is consumed as a no-operation.
        if (i_valid)
        begin
          r_next.pc = pc_plus_one(r_reg.pc);
          r_next.state = ST_EXEC;
        end
      end
      default:
      begin
        r_next.state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      r_reg.state <= ST_EXEC;
      r_reg.pc <= `BCBX_PC_RESET;
      r_reg.flush <= 1'b0;
      r_reg.push <= 1'b0;
      r_reg.push_addr <= `BCBX_PC_RESET;
      r_reg.wr_en <= 1'b0;
      r_reg.wr_addr <= 7'h00;
      r_reg.wr_data <= 8'h00;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign o_fetch_addr = r_reg.pc;
  assign o_ready = (r_reg.state != ST_BUBBLE);
  assign o_flush = r_reg.flush;
  assign o_push = r_reg.push;
  assign o_push_addr = r_reg.push_addr;
  assign o_wr_en = r_reg.wr_en;
  assign o_wr_addr = r_reg.wr_addr;
  assign o_wr_data = r_reg.wr_data;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_exec(bcbx_op_t op);
    exec && (i_op == op);
  endsequence

  sequence s_two_cycle;
    o_flush && !o_ready ##1 o_ready;
  endsequence

  rel_jump_target_a: assert property (s_exec(OP_RELATIVE_JUMP) |=>
      o_fetch_addr == 15'($past(r_reg.pc) + 15'h0001 + {{6{$past(i_lit[8])}}, $past(i_lit[8:0])}))
    else $error("Relative jump target wrong.");

  acc_jump_target_a: assert property (s_exec(OP_JUMP_BY_ACCUMULATOR) |=>
      o_fetch_addr == 15'($past(r_reg.pc) + 15'h0001 + {7'h00, $past(i_acc)}) ##0 s_two_cycle)
    else $error("Accumulator jump target or timing wrong.");

  set_bit_write_a: assert property (s_exec(OP_SET_BIT_OP) |=> o_wr_en &&
      o_wr_data[$past(i_bit_sel)] && ((o_wr_data ^ $past(i_file_data)) & ~(8'h01 << $past(i_bit_sel))) == 8'h00)
    else $error("Set bit wrote wrong value.");

  skip_low_a: assert property (s_exec(OP_SKIP_IF_BIT_LOW) |=>
      (r_reg.state == ST_SKIP) == !$past(i_file_data[i_bit_sel]))
    else $error("Skip on low bit wrong.");

  skip_high_a: assert property (s_exec(OP_SKIP_IF_BIT_HIGH) |=>
      (r_reg.state == ST_SKIP) == $past(i_file_data[i_bit_sel]))
    else $error("Skip on high bit wrong.");

  call_push_a: assert property (exec && dec_push |=> o_push &&
      o_push_addr == 15'($past(r_reg.pc) + 15'h0001))
    else $error("Call pushed wrong return address.");

  call_target_a: assert property (s_exec(OP_SUBROUTINE_CALL) |=>
      o_fetch_addr == {$past(i_latch[6:3]), $past(i_lit)} ##0 s_two_cycle)
    else $error("Direct call target or timing wrong.");

  indirect_call_a: assert property (s_exec(OP_INDIRECT_SUBROUTINE_CALL) |=>
      o_fetch_addr == {$past(i_latch), $past(i_acc)} ##0 s_two_cycle)
    else $error("Indirect call target or timing wrong.");

  bubble_hold_a: assert property (!o_ready |=> $stable(o_fetch_addr) && !o_flush)
    else $error("Bubble moved the fetch address.");

endmodule

/* File: test/bcbx_regfile_model.sv */
`timescale 1ns/1ps
`include "bcbx_params.svh"

module bcbx_regfile_model
(
  // Clock
  input wire logic i_clk,
  // Read port
  input wire logic [`BCBX_ADDR_W-1:0] i_addr,
  output logic [`BCBX_ACC_W-1:0] o_data,
  // Write port
  input wire logic i_wr_en,
  input wire logic [`BCBX_ADDR_W-1:0] i_wr_addr,
  input wire logic [`BCBX_ACC_W-1:0] i_wr_data
);
  logic [`BCBX_ACC_W-1:0] mem_reg [128];

  // A varied pattern lets every bit test meet both levels.
  initial
  begin
    for (int a = 0; a < 128; a++)
      mem_reg[a] = 8'(a * 37);
  end

  // The pending write is bypassed, so a back-to-back test sees the new byte.
  assign o_data = (i_wr_en && i_wr_addr == i_addr) ? i_wr_data : mem_reg[i_addr];

  // A plain process, because the initial block fills the same array.
  always @(posedge i_clk)
    if (i_wr_en)
      mem_reg[i_wr_addr] <= i_wr_data;
endmodule

/* File: test/branch_call_bit_execution_tb_top.sv */
`timescale 1ns/1ps
`include "bcbx_params.svh"
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end

module branch_call_bit_execution_tb_top;
  import bcbx_pkg::*;
  logic i_clk = 0;
  logic i_reset = 1;
  logic i_valid = 0;
  bcbx_op_t i_op = OP_OTHER;
  logic [10:0] i_lit = 0;
  logic [6:0] i_file_addr = 0;
  logic [2:0] i_bit_sel = 0;
  logic [7:0] i_file_data;
  logic [7:0] i_acc = 0;
  logic [6:0] i_latch = 0;
  logic [14:0] o_fetch_addr;
  logic [14:0] o_push_addr;
  logic o_ready;
  logic o_flush;
  logic o_push;
  logic o_wr_en;
  logic [6:0] o_wr_addr;
  logic [7:0] o_wr_data;
  logic [31:0] lfsr = 32'h44f2_b0ea;
  logic [14:0] pc_m = 0;
  logic [7:0] mem_m [128];
  logic skip_m = 0;
  logic sent = 0;
  logic [48:0] q [$];
  logic [48:0] n;
  int errors = 0;
  int tests_run = 0;

  initial forever #2.5 i_clk = ~i_clk;

  bcbx_core uut (.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op), .i_lit(i_lit),
    .i_file_addr(i_file_addr), .i_bit_sel(i_bit_sel), .i_file_data(i_file_data), .i_acc(i_acc),
    .i_latch(i_latch), .o_fetch_addr(o_fetch_addr), .o_ready(o_ready), .o_flush(o_flush),
    .o_push(o_push), .o_push_addr(o_push_addr), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data));

  bcbx_regfile_model rf (.i_clk(i_clk), .i_addr(i_file_addr), .o_data(i_file_data),
    .i_wr_en(o_wr_en), .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h8020_0003)};
    return lfsr;
  endfunction

  task automatic issue(input bcbx_op_t op, input logic [10:0] lit, input logic [6:0] a, input logic [2:0] b);
    logic [14:0] nx;
    logic [7:0] d;
    logic fl;
    logic pu;
    logic we;
    @(negedge i_clk);
    while (o_ready !== 1'b1 || (rnd() & 3) == 0)
    begin
      i_valid = 0;
      sent = 0;
      @(negedge i_clk);
    end
    i_op = op;
    i_lit = lit;
    i_file_addr = a;
    i_bit_sel = b;
    i_acc = 8'(rnd());
    i_latch = 7'(rnd());
    d = mem_m[a];
    nx = pc_m + 15'h0001;
    fl = 0;
    pu = 0;
    we = 0;
    if (skip_m)
      skip_m = 0;
    else
      case (op)
        OP_RELATIVE_JUMP: {fl, nx} = {1'b1, nx + {{6{lit[8]}}, lit[8:0]}};
        OP_JUMP_BY_ACCUMULATOR: {fl, nx} = {1'b1, nx + {7'h00, i_acc}};
        OP_SUBROUTINE_CALL: {fl, pu, nx} = {2'b11, i_latch[6:3], lit};
        OP_INDIRECT_SUBROUTINE_CALL: {fl, pu, nx} = {2'b11, i_latch, i_acc};
        OP_SET_BIT_OP: {we, d} = {1'b1, d | (8'h01 << b)};
        OP_SKIP_IF_BIT_LOW: skip_m = !d[b];
        OP_SKIP_IF_BIT_HIGH: skip_m = d[b];
        default: ;
      endcase
    if (we)
      mem_m[a] = d;
    q.push_back({nx, fl, !fl, pu, pu ? pc_m + 15'h0001 : 15'h0000, we, we ? {a, d} : 15'h0000});
    pc_m = nx;
    i_valid = 1;
    sent = 1;
  endtask

  always @(posedge i_clk)
    if (sent)
    begin
      #1;
      n = q.pop_front();
      `CHK("fetch flush ready", n[48:32], {o_fetch_addr, o_flush, o_ready})
      `CHK("push write", n[31:0], {o_push, o_push ? o_push_addr : 15'h0000, o_wr_en,
        o_wr_en ? {o_wr_addr, o_wr_data} : 15'h0000})
    end

  task end_sim;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #40000;
    errors++;
    end_sim;
  end

  initial
  begin
    for (int a = 0; a < 128; a++)
      mem_m[a] = 8'(a * 37);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 0;
    // Offset edges, the top bit and address, a taken skip over a call.
    issue(OP_RELATIVE_JUMP, 11'h100, 7'h00, 3'h0);
    issue(OP_RELATIVE_JUMP, 11'h0ff, 7'h00, 3'h0);
    issue(OP_SET_BIT_OP, 11'h000, 7'h7f, 3'h7);
    issue(OP_SKIP_IF_BIT_HIGH, 11'h000, 7'h7f, 3'h7);
    issue(OP_SUBROUTINE_CALL, 11'h7ff, 7'h00, 3'h0);
    issue(OP_SUBROUTINE_CALL, 11'h7ff, 7'h00, 3'h0);
    $display("directed test done");
    repeat (400) issue(bcbx_op_t'(rnd() & 7), 11'(rnd()), 7'(rnd()), 3'(rnd()));
    $display("random test done");
    @(negedge i_clk);
    i_valid = 1'b0;
    sent = 1'b0;
    // Let a pending register write land before reset cuts it off.
    @(negedge i_clk);
    i_reset = 1'b1;
    #1;
    `CHK("reset state", {o_fetch_addr, o_ready, o_flush, o_push, o_wr_en}, {15'h0000, 4'h8})
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    pc_m = 15'h0000;
    skip_m = 1'b0;
    issue(OP_SKIP_IF_BIT_LOW, 11'h000, 7'h00, 3'h0);
    issue(OP_INDIRECT_SUBROUTINE_CALL, 11'h000, 7'h00, 3'h0);
    issue(OP_JUMP_BY_ACCUMULATOR, 11'h000, 7'h00, 3'h0);
    $display("reset test done");
    @(negedge i_clk);
    i_valid = 1'b0;
    sent = 1'b0;
    repeat (2) @(negedge i_clk);
    end_sim;
  end
endmodule
